// >>> inc/brgf_pkg.sv
// constants and types for the bridge register file and pin port
package brgf_pkg;
   localparam int NPROG = 4;
   localparam int NPIN = 6;
   localparam int DATA_W = 8;
   localparam logic [2:0] IDX_TYPE = 3'h0;
   localparam logic [2:0] IDX_LEVEL = 3'h1;
   localparam logic [2:0] IDX_DIV = 3'h2;
   localparam logic [2:0] IDX_TO = 3'h3;
   localparam logic [2:0] IDX_RESULT = 3'h4;
   localparam logic [2:0] IDX_ADDR = 3'h5;
   localparam logic [7:0] RST_TYPE = 8'h00;
   localparam logic [7:0] RST_LEVEL = 8'h3f;
   localparam logic [7:0] RST_DIV = 8'h19;
   localparam logic [7:0] RST_TO = 8'hfe;
   localparam logic [7:0] RST_RESULT = 8'hf0;
   localparam logic [7:0] RST_ADDR = 8'h00;
   localparam logic [3:0] RESULT_ONES = 4'hf;
   localparam logic [1:0] LEVEL_RSV = 2'h0;
   localparam logic [1:0] STRONG_CYCLES = 2'h2;
   localparam int TE_BIT = 0;
   localparam int EXT_PIN = 3;
   typedef enum logic [1:0] {
      MODE_QUASI = 2'h0,
      MODE_INPUT = 2'h1,
      MODE_PUSH = 2'h2,
      MODE_ODRAIN = 2'h3
   } brgf_mode_t;
   typedef struct packed {
      logic very_weak_pu;
      logic weak_pu;
      logic strong_pu;
      logic pull_dn;
   } brgf_drive_t;
   typedef struct packed {
      logic [7:0] divider;
      logic [6:0] timeout_value;
      logic timeout_enable;
      logic [6:0] own_address;
   } brgf_bus_cfg_t;
endpackage

// >>> hdl/brgf_regs.sv
// register file, avalon slave and programmable pin port of the bridge
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// What this block does
// - six byte registers at indices zero to five
// - registers take documented defaults on reset
// - two type bits per programmable pin
// - type codes quasi, input, push-pull, open-drain
// - pins four and five always quasi
// - external clock variant ignores pin three
// - quasi very weak pull-up while latch one
// - quasi weak pull-up needs latch and pin high
// - quasi strong pull-up two cycles on rise
// - quasi latch zero drives firm pull-down
// - open-drain has pull-down only, latch zero
// - push-pull strong high, same pull-down low
// - input-only never drives, sampled through filter
// - level read returns sensed pin levels
// - level write loads latches of output pins
// - own address in bits seven to one
// - result read-only, upper nibble ones
// - time-out bit zero enables time-out
// - reset restores registers and bus logic
// - result read releases the interrupt
module brgf_regs
   import brgf_pkg::*;
#(
   parameter bit EXT_CLOCK_VARIANT = 1'b0
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // avalon-mm slave
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // pin port
   input wire logic [NPIN-1:0] pin_in_i,
   output logic [NPIN-1:0] pin_out_o,
   output logic [NPIN-1:0] pin_oe_o,
   output brgf_drive_t [NPIN-1:0] pin_drive_o,
   // two-wire engine side
   input wire logic result_load_i,
   input wire logic [3:0] result_code_i,
   input wire logic result_irq_i,
   output brgf_bus_cfg_t bus_cfg_o,
   // open-drain interrupt, active low on the wire
   output logic int_o,
   output logic int_oe_o
);

   logic [7:0] pin_type_select;
   logic [NPIN-1:0] pin_latch;
   logic [7:0] bus_clock_divider;
   logic [7:0] bus_timeout;
   logic [3:0] result_code;
   logic [7:0] own_bus_address;
   logic irq_pending;
   logic ack;
   logic [NPIN-1:0] sensed;
   logic [NPIN-1:0] pin_exists;
   logic [NPIN-1:0] pin_is_input;
   logic [NPIN-1:0] latch_rise;
   logic [NPIN-1:0] next_latch;
   brgf_mode_t [NPIN-1:0] pin_mode;
   logic [2:0] idx;
   logic req;
   logic wr_go;
   logic rd_go;
   logic [7:0] rd_mux;
   logic [7:0] wbyte;

   assign idx = avs_address_i[4:2];
   assign req = avs_read_i | avs_write_i;
   assign wr_go = avs_write_i & ack & avs_byteenable_i[0];
   assign rd_go = avs_read_i & ack;
   assign wbyte = avs_writedata_i[7:0];
   // one wait cycle gives a registered read path
   assign avs_waitrequest_o = req & ~ack;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ack <= 1'b0;
      end else begin
         ack <= req & ~ack;
      end
   end

   always_comb begin
      rd_mux = 8'h00;
      case (idx)
         IDX_TYPE: rd_mux = pin_type_select;
         IDX_LEVEL: rd_mux = {LEVEL_RSV, sensed & pin_exists};
         IDX_DIV: rd_mux = bus_clock_divider;
         IDX_TO: rd_mux = bus_timeout;
         IDX_RESULT: rd_mux = {RESULT_ONES, result_code};
         IDX_ADDR: rd_mux = own_bus_address;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_read_i & ~ack) begin
         avs_readdata_o <= {24'h00_0000, rd_mux};
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pin_type_select <= RST_TYPE;
         bus_clock_divider <= RST_DIV;
         bus_timeout <= RST_TO;
         own_bus_address <= RST_ADDR;
      end else if (wr_go) begin
         case (idx)
            IDX_TYPE: pin_type_select <= wbyte;
            IDX_DIV: bus_clock_divider <= wbyte;
            IDX_TO: bus_timeout <= wbyte;
            IDX_ADDR: own_bus_address <= wbyte;
            default: ;
         endcase
      end
   end

   // input-only and absent pins keep their latch
   assign next_latch = (wr_go && idx == IDX_LEVEL) ?
      ((wbyte[NPIN-1:0] & ~pin_is_input & pin_exists) | (pin_latch & (pin_is_input | ~pin_exists))) :
      pin_latch;
   assign latch_rise = next_latch & ~pin_latch;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pin_latch <= RST_LEVEL[NPIN-1:0];
      end else begin
         pin_latch <= next_latch;
      end
   end

   // result code is written only by the engine
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         result_code <= RST_RESULT[3:0];
      end else if (result_load_i) begin
         result_code <= result_code_i;
      end
   end

   // a new event in the clearing cycle wins
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_pending <= 1'b0;
      end else if (result_load_i & result_irq_i) begin
         irq_pending <= 1'b1;
      end else if (rd_go && idx == IDX_RESULT) begin
         irq_pending <= 1'b0;
      end
   end

   assign int_o = 1'b0;
   assign int_oe_o = irq_pending;

   assign bus_cfg_o.divider = bus_clock_divider;
   assign bus_cfg_o.timeout_value = bus_timeout[7:1];
   assign bus_cfg_o.timeout_enable = bus_timeout[TE_BIT];
   assign bus_cfg_o.own_address = own_bus_address[7:1];

   genvar i;
   generate
      for (i = 0; i < NPIN; i++) begin : g_pin
         logic samp;
         logic [1:0] strong_cnt;
         brgf_drive_t drv;

         if (i < NPROG) begin : g_prog
            assign pin_mode[i] = brgf_mode_t'(pin_type_select[2*i+1 -: 2]);
            assign pin_exists[i] = !(EXT_CLOCK_VARIANT && i == EXT_PIN);
         end else begin : g_fixed
            assign pin_mode[i] = MODE_QUASI;
            assign pin_exists[i] = 1'b1;
         end
         assign pin_is_input[i] = (pin_mode[i] == MODE_INPUT);

         // glitch filter: a level must hold two samples
         always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               samp <= 1'b1;
               sensed[i] <= 1'b1;
            end else begin
               samp <= pin_in_i[i];
               if (samp == pin_in_i[i]) begin
                  sensed[i] <= samp;
               end
            end
         end

         always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               strong_cnt <= 2'h0;
            end else if (latch_rise[i] && pin_mode[i] == MODE_QUASI) begin
               strong_cnt <= STRONG_CYCLES;
            end else if (strong_cnt != 2'h0) begin
               strong_cnt <= strong_cnt - 2'h1;
            end
         end

         always_comb begin
            drv = '0;
            if (pin_exists[i]) begin
               case (pin_mode[i])
                  MODE_QUASI: begin
                     drv.very_weak_pu = pin_latch[i];
                     drv.weak_pu = pin_latch[i] & sensed[i];
                     drv.strong_pu = (strong_cnt != 2'h0);
                     drv.pull_dn = ~pin_latch[i];
                  end
                  MODE_PUSH: begin
                     drv.strong_pu = pin_latch[i];
                     drv.pull_dn = ~pin_latch[i];
                  end
                  MODE_ODRAIN: begin
                     drv.pull_dn = ~pin_latch[i];
                  end
                  default: drv = '0;
               endcase
            end
         end

         assign pin_drive_o[i] = drv;
         assign pin_out_o[i] = drv.strong_pu;
         assign pin_oe_o[i] = drv.strong_pu | drv.pull_dn;

         strong_pulse_a: assert property (
            @(posedge sys_clk_i) disable iff (!arst_n_i)
            (latch_rise[i] && pin_mode[i] == MODE_QUASI && pin_exists[i])
            |=> drv.strong_pu [*2] ##1 !drv.strong_pu
         ) else $error("strong pull-up not two cycles");

         weak_pullup_a: assert property (
            @(posedge sys_clk_i) disable iff (!arst_n_i)
            (pin_mode[i] == MODE_QUASI && pin_exists[i] && pin_latch[i] && !sensed[i])
            |-> !drv.weak_pu && drv.very_weak_pu
         ) else $error("weak pull-up on with pin held low");

         odrain_pull_a: assert property (
            @(posedge sys_clk_i) disable iff (!arst_n_i)
            (pin_mode[i] == MODE_ODRAIN && pin_exists[i])
            |-> !(drv.very_weak_pu | drv.weak_pu | drv.strong_pu) && (drv.pull_dn == !pin_latch[i])
         ) else $error("open-drain drive wrong");

         input_nodrive_a: assert property (
            @(posedge sys_clk_i) disable iff (!arst_n_i)
            (pin_mode[i] == MODE_INPUT) |-> !pin_oe_o[i] && drv == '0
         ) else $error("input-only pin driven");

         push_level_a: assert property (
            @(posedge sys_clk_i) disable iff (!arst_n_i)
            (pin_mode[i] == MODE_PUSH && pin_exists[i])
            |-> pin_oe_o[i] && pin_out_o[i] == pin_latch[i]
         ) else $error("push-pull level wrong");

         glitch_filter_a: assert property (
            @(posedge sys_clk_i) disable iff (!arst_n_i)
            (pin_in_i[i] != sensed[i]) ##1 (pin_in_i[i] != $past(pin_in_i[i]))
            |=> $stable(sensed[i])
         ) else $error("one-sample glitch reached sensed level");
      end
   endgenerate

   fixed_quasi_a: assert property (
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      wr_go && idx == IDX_TYPE |=> pin_mode[4] == MODE_QUASI && pin_mode[5] == MODE_QUASI
   ) else $error("fixed pin left quasi mode");

   ext_pin_off_a: assert property (
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      EXT_CLOCK_VARIANT |-> pin_drive_o[EXT_PIN] == '0 && !pin_oe_o[EXT_PIN]
   ) else $error("absent pin driven");

   level_read_a: assert property (
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (avs_read_i && !ack && idx == IDX_LEVEL)
      |=> avs_readdata_o[7:6] == LEVEL_RSV && avs_readdata_o[5:0] == $past(sensed & pin_exists)
   ) else $error("level read wrong");

   result_ro_a: assert property (
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (wr_go && idx == IDX_RESULT && !result_load_i) |=> $stable(result_code)
   ) else $error("result code changed by host write");

   result_ones_a: assert property (
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (avs_read_i && !ack && idx == IDX_RESULT) |=> avs_readdata_o[7:4] == RESULT_ONES
   ) else $error("result upper nibble not ones");

   irq_clear_a: assert property (
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (rd_go && idx == IDX_RESULT && !(result_load_i && result_irq_i)) |=> !int_oe_o
   ) else $error("interrupt not released by result read");

   level_write_a: assert property (
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (wr_go && idx == IDX_LEVEL && pin_mode[0] != MODE_INPUT)
      |=> pin_latch[0] == $past(wbyte[0]) && pin_latch[5] == $past(wbyte[5])
   ) else $error("latch not loaded from level write");

   div_write_a: assert property (
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (wr_go && idx == IDX_DIV) |=> bus_cfg_o.divider == $past(wbyte)
   ) else $error("divider write lost");

   wait_one_a: assert property (
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (req && !ack) |=> !avs_waitrequest_o
   ) else $error("waitrequest held too long");
endmodule

// >>> sim/brgf_host.sv
// host model: avalon master making one register access per command
`timescale 1ns/1ps
module brgf_host (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // command side
   input wire logic go_i,
   input wire logic wr_i,
   input wire logic [2:0] idx_i,
   input wire logic [7:0] wdata_i,
   output logic done_o,
   output logic [7:0] rdata_o,
   // avalon master
   output logic [4:0] address_o,
   output logic read_o,
   output logic write_o,
   output logic [31:0] writedata_o,
   output logic [3:0] byteenable_o,
   input wire logic [31:0] readdata_i,
   input wire logic waitrequest_i
);
   assign byteenable_o = 4'h1;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         read_o <= 1'b0;
         write_o <= 1'b0;
         done_o <= 1'b0;
         address_o <= 5'h00;
         writedata_o <= 32'h0;
         rdata_o <= 8'h00;
      end else begin
         done_o <= 1'b0;
         if ((read_o | write_o) && !waitrequest_i) begin
            read_o <= 1'b0;
            write_o <= 1'b0;
            done_o <= 1'b1;
            rdata_o <= readdata_i[7:0];
            // released data must not keep looking valid
            writedata_o <= ~writedata_o;
            address_o <= ~address_o;
         end else if (go_i && !(read_o | write_o)) begin
            address_o <= {idx_i, 2'h0};
            read_o <= !wr_i;
            write_o <= wr_i;
            writedata_o <= {24'h0, wdata_i[7:1], wdata_i[0] & (idx_i != 3'h5)};
         end
      end
   end
endmodule

// >>> sim/tb_top.sv
// testbench for the bridge register file and pin port
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module tb_top
   import brgf_pkg::*;
;
   logic clk;
   logic rst_n = 1'b0, go = 1'b0, wr = 1'b0, ld = 1'b0, irq = 1'b0, done, r, w, wq, int_oe;
   logic [2:0] idx = 3'h0;
   logic [7:0] wd = 8'h00, rd, q;
   logic [3:0] code = 4'h0, be;
   logic [5:0] ext_low = 6'h00, pin_in, oe;
   logic [4:0] a;
   logic [31:0] wdat, rdat;
   brgf_drive_t [5:0] drv;
   brgf_drive_t [5:0] drv_x;
   brgf_bus_cfg_t cfg;
   int num_errors = 0, n_tests = 0, sc = 0;

   // pad: pulled high unless pulled down by the pin or an outside driver
   always_comb for (int j = 0; j < 6; j++) pin_in[j] = ~(drv[j].pull_dn | ext_low[j]);
   always @(posedge clk) sc <= sc + int'(drv[0].strong_pu);

   brgf_host u_host (.clk_i(clk), .rst_n_i(rst_n), .go_i(go), .wr_i(wr), .idx_i(idx), .wdata_i(wd),
      .done_o(done), .rdata_o(rd), .address_o(a), .read_o(r), .write_o(w), .writedata_o(wdat),
      .byteenable_o(be), .readdata_i(rdat), .waitrequest_i(wq));
   brgf_regs #(.EXT_CLOCK_VARIANT(1'b0)) u_dut (.sys_clk_i(clk), .arst_n_i(rst_n), .avs_address_i(a),
      .avs_read_i(r), .avs_write_i(w), .avs_writedata_i(wdat), .avs_byteenable_i(be),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .pin_in_i(pin_in), .pin_out_o(), .pin_oe_o(oe),
      .pin_drive_o(drv), .result_load_i(ld), .result_code_i(code), .result_irq_i(irq),
      .bus_cfg_o(cfg), .int_o(), .int_oe_o(int_oe));
   // external clock variant shares the bus; only its pin three drive is judged
   brgf_regs #(.EXT_CLOCK_VARIANT(1'b1)) u_dut_ext (.sys_clk_i(clk), .arst_n_i(rst_n), .avs_address_i(a),
      .avs_read_i(r), .avs_write_i(w), .avs_writedata_i(wdat), .avs_byteenable_i(be),
      .avs_readdata_o(), .avs_waitrequest_o(), .pin_in_i(pin_in), .pin_out_o(), .pin_oe_o(),
      .pin_drive_o(drv_x), .result_load_i(ld), .result_code_i(code), .result_irq_i(irq),
      .bus_cfg_o(), .int_o(), .int_oe_o());

   task automatic tally_and_finish;
      $display("errors %0d tests %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic acc(input logic wi, input logic [2:0] i, input logic [7:0] d);
      int k = 0;
      @(posedge clk);
      go <= 1'b1;
      wr <= wi;
      idx <= i;
      wd <= d;
      @(posedge clk);
      go <= 1'b0;
      do begin
         @(negedge clk);
         k++;
      end while (done !== 1'b1 && k < 20);
      `CHK(done, 1'b1)
      q = rd;
   endtask

   task automatic rx(input logic [2:0] i, input logic [7:0] e);
      acc(1'b0, i, 8'h00);
      `CHK(q, e)
   endtask

   task automatic t_reset;
      logic [7:0] e [7];
      e = '{8'h00, 8'h3f, 8'h19, 8'hfe, 8'hf0, 8'h00, 8'h00};
      for (int i = 0; i < 7; i++) begin
         rx(3'(i), e[i]);
      end
      `CHK(cfg.timeout_enable, 1'b0)
   endtask

   task automatic t_regs;
      acc(1'b1, 3'h2, 8'ha5);
      acc(1'b1, 3'h3, 8'h81);
      acc(1'b1, 3'h5, 8'hb5);
      acc(1'b1, 3'h4, 8'h0f);
      acc(1'b1, 3'h1, 8'hff);
      acc(1'b1, 3'h6, 8'h55);
      rx(3'h2, 8'ha5);
      rx(3'h3, 8'h81);
      rx(3'h5, 8'hb4);
      rx(3'h4, 8'hf0);
      rx(3'h1, 8'h3f);
      rx(3'h6, 8'h00);
      `CHK(cfg.divider, 8'ha5)
      `CHK(cfg.timeout_value, 7'h40)
      `CHK(cfg.timeout_enable, 1'b1)
      `CHK(cfg.own_address, 7'h5a)
   endtask

   task automatic t_quasi;
      int s0;
      acc(1'b1, 3'h1, 8'h3e);
      cyc(4);
      `CHK(drv[0], 4'h1)
      `CHK(oe[0], 1'b1)
      s0 = sc;
      acc(1'b1, 3'h1, 8'h3f);
      cyc(6);
      `CHK(sc - s0, 2)
      `CHK(drv[0], 4'hc)
      @(posedge clk);
      ext_low <= 6'h01;
      cyc(5);
      `CHK(drv[0], 4'h8)
      rx(3'h1, 8'h3e);
      @(posedge clk);
      ext_low <= 6'h00;
   endtask

   task automatic t_modes;
      acc(1'b1, 3'h0, 8'h1e);
      rx(3'h0, 8'h1e);
      acc(1'b1, 3'h1, 8'h00);
      cyc(5);
      `CHK(drv[0], 4'h1)
      `CHK(drv[1], 4'h1)
      `CHK(drv[2], 4'h0)
      `CHK(oe[2], 1'b0)
      `CHK(drv[3], 4'h1)
      `CHK(drv_x[3], 4'h0)
      `CHK(drv[4], 4'h1)
      rx(3'h1, 8'h04);
      acc(1'b1, 3'h1, 8'h3f);
      cyc(5);
      `CHK(drv[0], 4'h2)
      `CHK(drv[1], 4'h0)
      `CHK(drv[5], 4'hc)
   endtask

   task automatic t_irq;
      @(posedge clk);
      ld <= 1'b1;
      code <= 4'h8;
      irq <= 1'b1;
      @(posedge clk);
      ld <= 1'b0;
      irq <= 1'b0;
      cyc(1);
      `CHK(int_oe, 1'b1)
      rx(3'h4, 8'hf8);
      `CHK(int_oe, 1'b0)
   endtask

   task automatic t_rst;
      acc(1'b1, 3'h2, 8'h33);
      @(posedge clk);
      ld <= 1'b1;
      irq <= 1'b1;
      @(posedge clk);
      ld <= 1'b0;
      irq <= 1'b0;
      rst_n <= 1'b0;
      cyc(2);
      `CHK(cfg.divider, 8'h19)
      `CHK(int_oe, 1'b0)
      @(posedge clk);
      rst_n <= 1'b1;
      rx(3'h2, 8'h19);
      rx(3'h0, 8'h00);
   endtask

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // whole run is well under a thousand cycles; this leaves wide margin
   initial begin
      #100000;
      num_errors++;
      tally_and_finish();
   end

   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_regs();
      t_quasi();
      t_modes();
      t_irq();
      t_rst();
      tally_and_finish();
   end
endmodule
